//--- common/vwsh_defines.vh
`ifndef VWSH_DEFINES_VH
`define VWSH_DEFINES_VH
// ==========================================================
// register map (byte addresses)
`define VWSH_ADDR_CMD        4'h0
`define VWSH_ADDR_REPLY      4'h4
`define VWSH_ADDR_STATUS     4'h8
`define VWSH_ADDR_STB        4'hc
// ==========================================================
// command word fields
`define VWSH_OP_RANGE        15:9
`define VWSH_FLAG_BIT        8
`define VWSH_ARG_RANGE       7:0
// ==========================================================
// opcodes (upper seven bits of the command word)
`define VWSH_OP_BYTE_AVAIL   7'h5e
`define VWSH_OP_BYTE_REQ     7'h6f
`define VWSH_OP_CLEAR        7'h7f
`define VWSH_OP_CTRL_EVENT   7'h57
`define VWSH_OP_CTRL_RESP    7'h50
`define VWSH_OP_END_NORMAL   7'h7d
`define VWSH_OP_BEGIN_NORMAL 7'h7c
`define VWSH_OP_ABORT_NORMAL 7'h7e
`define VWSH_OP_ASSIGN_LINE  7'h53
`define VWSH_OP_READ_LINE    7'h59
`define VWSH_OP_READ_NINT    7'h4d
`define VWSH_OP_READ_PROT    7'h67
`define VWSH_OP_READ_ERR     7'h60
`define VWSH_OP_READ_STB     7'h4f
`define VWSH_OP_ASYNC_MODE   7'h54
// ==========================================================
// reply words and values
`define VWSH_PROTOCOL_WORD   16'h8623
`define VWSH_NUM_INTR        16'h0001
`define VWSH_LINE_DEFAULT    3'h0
`define VWSH_STAT_BASE       16'hfff0
`define VWSH_STAT_OK         4'hf
`define VWSH_STAT_NOT_NORMAL 4'h7
`define VWSH_ERR_NONE        16'hffff
`define VWSH_ERR_MULTI_QUERY 16'hfffd
`define VWSH_ERR_UNSUPPORTED 16'hfffc
`define VWSH_ERR_DIR         16'hfffb
`define VWSH_ERR_DOR         16'hfffa
`define VWSH_ERR_WRITE_READY 16'hfff9
// ==========================================================
// event codes, also the argument of the control-event command
`define VWSH_EVT_REQ_TRUE    8'hfd
`define VWSH_EVT_REQ_FALSE   8'hfc
// async mode argument: bit0 events as interrupts, bits 3:1 unsupported
`define VWSH_ASYNC_EVT_INT   0
`define VWSH_ASYNC_BAD_RANGE 3:1
// ==========================================================
// status register bits
`define VWSH_ST_NORMAL       0
`define VWSH_ST_TOP          1
`define VWSH_ST_ERR          2
`define VWSH_ST_REPLY        3
`define VWSH_ST_EVT_INT      4
`define VWSH_ST_EN_TRUE      5
`define VWSH_ST_EN_FALSE     6
`define VWSH_ST_LINE_RANGE   10:8
// ==========================================================
// message fifo shape
`define VWSH_FIFO_WIDTH      9
`define VWSH_FIFO_DEPTH      16
`define VWSH_FIFO_CNT_W      5
`endif

//--- design/vwsh_core.v
// Functional notes
// - byte-available accepted only in normal operation, refused with an unsupported error in configure.
// - flag bit 8 on byte-available marks the final byte of a message.
// - byte-request in normal operation returns the next response byte.
// - clear in configure empties buffers and drops any pending protocol error.
// - control-event in configure enables or disables request-true or request-false.
// - both request event enables are on after reset.
// - request-true event on service request rising, if routed and enabled.
// - request-false event on service request falling, if routed and enabled.
// - control-response accepted in configure; enabling any response is an error.
// - end-normal-operation returns from normal operation to configure.
// - end-normal-operation in configure replies status 7.
// - read-interrupter-line returns the assigned line, default 0.
// - read-interrupters replies 1.
// - read-protocol replies the capability word 8623 hex.
// - begin-normal-operation enters normal operation; bit 8 marks top level.
// - read-protocol-error returns the cause of the current error.
`timescale 1ns/1ps
`include "vwsh_defines.vh"

module vwsh_core (
  input  wire        clk,
  input  wire        reset,
  // register port
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // message bytes toward the instrument parser
  output wire        msg_valid,
  output wire [7:0]  msg_data,
  output wire        msg_end,
  input  wire        msg_ready,
  // response bytes from the instrument parser
  input  wire        rsp_valid,
  input  wire [7:0]  rsp_data,
  input  wire        rsp_end,
  output reg         rsp_take,
  // status byte and interrupter
  input  wire [7:0]  stb,
  input  wire        srq,
  output wire        evt_valid,
  output wire [7:0]  evt_word,
  output reg  [2:0]  int_line,
  output reg         normal_mode
);
  // ==========================================================
  // state
  localparam CONFIGURE = 1'b0;
  localparam NORMAL    = 1'b1;

  reg        top_q;
  reg        route_int_q;
  reg        en_true_q;
  reg        en_false_q;
  reg        err_q;
  reg [15:0] err_code_q;
  reg        reply_valid_q;
  reg [15:0] reply_q;

  // ==========================================================
  // decode helpers
  wire       cmd_wr;
  wire [6:0] op;
  wire       flag;
  wire [7:0] arg;
  wire       fifo_in_ready;
  wire       fifo_push;
  wire       quiet;

  assign cmd_wr = wr && (addr == `VWSH_ADDR_CMD);
  assign op     = wdata[`VWSH_OP_RANGE];
  assign flag   = wdata[`VWSH_FLAG_BIT];
  assign arg    = wdata[`VWSH_ARG_RANGE];

  // status-field reply word
  function [15:0] stat_word;
    input [3:0] code;
    begin
      stat_word = `VWSH_STAT_BASE | {12'h000, code};
    end
  endfunction

  // ==========================================================
  // command interpreter, next values
  reg        next_mode;
  reg        next_top;
  reg        next_route;
  reg        next_en_true;
  reg        next_en_false;
  reg [2:0]  next_line;
  reg        set_reply;
  reg [15:0] new_reply;
  reg        set_err;
  reg [15:0] new_err;
  reg        clr_err;
  reg        do_flush;
  reg        do_take;
  reg        do_push;
  reg        do_quiet;

  always @* begin
    next_mode     = normal_mode;
    next_top      = top_q;
    next_route    = route_int_q;
    next_en_true  = en_true_q;
    next_en_false = en_false_q;
    next_line     = int_line;
    set_reply     = 1'b0;
    new_reply     = reply_q;
    set_err       = 1'b0;
    new_err       = err_code_q;
    clr_err       = 1'b0;
    do_flush      = 1'b0;
    do_take       = 1'b0;
    do_push       = 1'b0;
    do_quiet      = 1'b0;
    if (cmd_wr) begin
      case (op)
        `VWSH_OP_BYTE_AVAIL: begin
          if (normal_mode == NORMAL) begin
            if (fifo_in_ready) begin
              do_push = 1'b1;
            end else begin
              set_err = 1'b1;   // no room: data-in violation
              new_err = `VWSH_ERR_DIR;
            end
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_BYTE_REQ: begin
          if (normal_mode != NORMAL) begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end else if (!rsp_valid) begin
            set_err = 1'b1;   // nothing to send: data-out violation
            new_err = `VWSH_ERR_DOR;
          end else begin
            do_take   = 1'b1;
            set_reply = 1'b1;
            new_reply = {7'h00, rsp_end, rsp_data};
          end
        end
        `VWSH_OP_CLEAR: begin
          if (normal_mode == CONFIGURE) begin
            do_flush = 1'b1;
            clr_err  = 1'b1;
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_CTRL_EVENT: begin
          if (normal_mode == CONFIGURE && arg == `VWSH_EVT_REQ_TRUE) begin
            next_en_true = flag;
          end else if (normal_mode == CONFIGURE && arg == `VWSH_EVT_REQ_FALSE) begin
            next_en_false = flag;
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_CTRL_RESP: begin
          if (normal_mode != CONFIGURE || arg != 8'h00) begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_END_NORMAL: begin
          set_reply = 1'b1;
          if (normal_mode == NORMAL) begin
            next_mode = CONFIGURE;
            new_reply = stat_word(`VWSH_STAT_OK);
          end else begin
            new_reply = stat_word(`VWSH_STAT_NOT_NORMAL);
          end
        end
        `VWSH_OP_BEGIN_NORMAL: begin
          if (normal_mode == CONFIGURE) begin
            next_mode = NORMAL;
            next_top  = flag;
            set_reply = 1'b1;
            new_reply = stat_word(`VWSH_STAT_OK);
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_ABORT_NORMAL: begin
          if (normal_mode == CONFIGURE) begin
            // back to the power-up configuration, interrupter quiet
            next_top      = 1'b0;
            next_route    = 1'b0;
            next_en_true  = 1'b1;
            next_en_false = 1'b1;
            next_line     = `VWSH_LINE_DEFAULT;
            do_quiet      = 1'b1;
            set_reply     = 1'b1;
            new_reply     = stat_word(`VWSH_STAT_OK);
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_ASSIGN_LINE: begin
          if (normal_mode == CONFIGURE) begin
            next_line = arg[2:0];
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_ASYNC_MODE: begin
          if (normal_mode == CONFIGURE && arg[`VWSH_ASYNC_BAD_RANGE] == 3'h0) begin
            next_route = arg[`VWSH_ASYNC_EVT_INT];
          end else begin
            set_err = 1'b1;   // only events as interrupts
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_READ_LINE: begin
          if (normal_mode == CONFIGURE) begin
            set_reply = 1'b1;
            new_reply = {13'h0000, int_line};
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_READ_NINT: begin
          if (normal_mode == CONFIGURE) begin
            set_reply = 1'b1;
            new_reply = `VWSH_NUM_INTR;
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_READ_PROT: begin
          if (normal_mode == CONFIGURE) begin
            set_reply = 1'b1;
            new_reply = `VWSH_PROTOCOL_WORD;
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        `VWSH_OP_READ_ERR: begin
          set_reply = 1'b1;
          new_reply = err_q ? err_code_q : `VWSH_ERR_NONE;
          clr_err   = 1'b1;
        end
        `VWSH_OP_READ_STB: begin
          if (normal_mode == NORMAL) begin
            set_reply = 1'b1;
            new_reply = {8'h00, stb};
          end else begin
            set_err = 1'b1;
            new_err = `VWSH_ERR_UNSUPPORTED;
          end
        end
        default: begin
          set_err = 1'b1;   // unknown opcode
          new_err = `VWSH_ERR_UNSUPPORTED;
        end
      endcase
      // a second query before the first answer was read is refused
      if (set_reply && reply_valid_q) begin
        set_reply = 1'b0;
        do_take   = 1'b0;
        set_err   = 1'b1;
        new_err   = `VWSH_ERR_MULTI_QUERY;
      end
    end
  end

  assign fifo_push = do_push;
  assign quiet     = do_quiet;

  // ==========================================================
  // control and configuration registers
  always @(posedge clk) begin
    if (reset) begin
      normal_mode <= CONFIGURE;
      top_q       <= 1'b0;
      route_int_q <= 1'b0;
      en_true_q   <= 1'b1;
      en_false_q  <= 1'b1;
      int_line    <= `VWSH_LINE_DEFAULT;
      rsp_take    <= 1'b0;
    end else begin
      normal_mode <= next_mode;
      top_q       <= next_top;
      route_int_q <= next_route;
      en_true_q   <= next_en_true;
      en_false_q  <= next_en_false;
      int_line    <= next_line;
      rsp_take    <= do_take;   // one-cycle pop of the response byte
    end
  end

  // ==========================================================
  // error flag: a new error wins over a clear in the same cycle
  always @(posedge clk) begin
    if (reset) begin
      err_q      <= 1'b0;
      err_code_q <= `VWSH_ERR_NONE;
    end else if (set_err) begin
      err_q      <= 1'b1;
      err_code_q <= new_err;
    end else if (clr_err) begin
      err_q      <= 1'b0;
      err_code_q <= `VWSH_ERR_NONE;
    end
  end

  // ==========================================================
  // reply word; reading it frees the slot for the next query
  always @(posedge clk) begin
    if (reset) begin
      reply_valid_q <= 1'b0;
      reply_q       <= 16'h0000;
    end else if (set_reply) begin
      reply_valid_q <= 1'b1;
      reply_q       <= new_reply;
    end else if (do_flush || (rd && addr == `VWSH_ADDR_REPLY)) begin
      reply_valid_q <= 1'b0;
    end
  end

  // ==========================================================
  // register reads, answered in the following cycle
  always @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `VWSH_ADDR_REPLY: begin
          rdata <= {16'h0000, reply_q};
        end
        `VWSH_ADDR_STATUS: begin
          rdata <= 32'h00000000;
          rdata[`VWSH_ST_NORMAL]     <= normal_mode;
          rdata[`VWSH_ST_TOP]        <= top_q;
          rdata[`VWSH_ST_ERR]        <= err_q;
          rdata[`VWSH_ST_REPLY]      <= reply_valid_q;
          rdata[`VWSH_ST_EVT_INT]    <= route_int_q;
          rdata[`VWSH_ST_EN_TRUE]    <= en_true_q;
          rdata[`VWSH_ST_EN_FALSE]   <= en_false_q;
          rdata[`VWSH_ST_LINE_RANGE] <= int_line;
        end
        `VWSH_ADDR_STB: begin
          rdata <= {24'h000000, stb};
        end
        default: begin
          rdata <= 32'h00000000;   // command port and holes read zero
        end
      endcase
    end
  end

  // ==========================================================
  // message byte buffer; a full buffer refuses with a data-in error
  // rather than stalling, since the register port never waits
  vwsh_fifo #(
    .WIDTH (`VWSH_FIFO_WIDTH),
    .DEPTH (`VWSH_FIFO_DEPTH),
    .CNT_W (`VWSH_FIFO_CNT_W)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (do_flush),
    .in_valid  (fifo_push),
    .in_data   ({flag, arg}),
    .in_ready  (fifo_in_ready),
    .out_valid (msg_valid),
    .out_data  ({msg_end, msg_data}),
    .out_ready (msg_ready)
  );

  // ==========================================================
  // service-request events
  vwsh_event u_event (
    .clk       (clk),
    .reset     (reset),
    .quiet     (quiet),
    .srq       (srq),
    .route_int (route_int_q),
    .en_true   (en_true_q),
    .en_false  (en_false_q),
    .evt_valid (evt_valid),
    .evt_word  (evt_word)
  );
endmodule

//--- design/vwsh_event.v
`timescale 1ns/1ps
// ==========================================================
// service-request edge watcher: turns status-byte request edges
// into one-cycle event words when routing and enables allow
module vwsh_event (
  input  wire       clk,
  input  wire       reset,
  input  wire       quiet,
  input  wire       srq,
  input  wire       route_int,
  input  wire       en_true,
  input  wire       en_false,
  output reg        evt_valid,
  output reg  [7:0] evt_word
);
  reg srq_prev_q;

  // edges are taken against the last seen level; quiet holds the
  // interrupter unasserted while the block returns to defaults
  always @(posedge clk) begin
    if (reset) begin
      srq_prev_q <= 1'b0;
      evt_valid  <= 1'b0;
      evt_word   <= 8'h00;
    end else begin
      srq_prev_q <= srq;
      evt_valid  <= 1'b0;
      if (!quiet && route_int) begin
        if (srq && !srq_prev_q && en_true) begin
          evt_valid <= 1'b1;
          evt_word  <= `VWSH_EVT_REQ_TRUE;
        end else if (!srq && srq_prev_q && en_false) begin
          evt_valid <= 1'b1;
          evt_word  <= `VWSH_EVT_REQ_FALSE;
        end
      end
    end
  end
endmodule

//--- design/vwsh_fifo.v
`timescale 1ns/1ps
// ==========================================================
// shift-register fifo; the head always sits in slot 0 so the
// read side sees flip-flops only, at the cost of a shift per pop
module vwsh_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter CNT_W = 5
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             flush,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  output reg              out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] cnt_d;
  reg  [CNT_W-1:0] wr_idx;
  wire             push;
  wire             pop;
  integer          i;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem_q[0];

  // next fill level and the slot that a push lands in
  always @* begin
    cnt_d  = cnt_q;
    wr_idx = cnt_q;
    if (pop) begin
      wr_idx = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (push && !pop) begin
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (pop && !push) begin
      cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // storage: shift on pop, then drop the new word in place
  always @(posedge clk) begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (pop && i < DEPTH - 1) begin
        mem_q[i] <= mem_q[i+1];
      end
      if (push && i == wr_idx) begin
        mem_q[i] <= in_data;
      end
    end
  end

  // level and flags, flushed as one
  always @(posedge clk) begin
    if (reset || flush) begin
      cnt_q     <= {CNT_W{1'b0}};
      out_valid <= 1'b0;
      in_ready  <= 1'b1;
    end else begin
      cnt_q     <= cnt_d;
      out_valid <= (cnt_d != {CNT_W{1'b0}});
      in_ready  <= (cnt_d != DEPTH[CNT_W-1:0]);
    end
  end
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
`include "vwsh_defines.vh"
// ==========================================================
// bench top: register master, parser model, request-bit driver
module tb;
  logic        clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, srq = 1'b0, stall = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, d;
  logic [7:0]  stb = 8'h00, last_evt = 8'h00;
  wire  [31:0] rdata;
  wire         msg_valid, msg_end, msg_ready, rsp_valid, rsp_end, rsp_take, evt_valid;
  wire         normal_mode;
  wire  [7:0]  msg_data, rsp_data, evt_word;
  wire  [2:0]  int_line;
  int          n_errors = 0, check_count = 0, cycles = 0, n_evt = 0;
  always #5 clk = ~clk;
  vwsh_core vwsh_core_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .msg_valid(msg_valid), .msg_data(msg_data), .msg_end(msg_end),
    .msg_ready(msg_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_end(rsp_end),
    .rsp_take(rsp_take), .stb(stb), .srq(srq), .evt_valid(evt_valid), .evt_word(evt_word),
    .int_line(int_line), .normal_mode(normal_mode));
  vwsh_parser_model parser_i (.clk(clk), .stall(stall), .msg_valid(msg_valid),
    .msg_data(msg_data), .msg_end(msg_end), .msg_ready(msg_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_end(rsp_end), .rsp_take(rsp_take));
  // ==========================================================
  // checking and bus tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task cmd(input logic [6:0] op, input logic flag, input logic [7:0] arg);
    @(posedge clk);
    addr  <= `VWSH_ADDR_CMD;
    wdata <= {16'h0000, op, flag, arg};
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  // command whose reply, if any, is read away so later queries stay legal
  task do_cmd(input logic [6:0] op, input logic flag, input logic [7:0] arg);
    cmd(op, flag, arg);
    rd_reg(`VWSH_ADDR_REPLY, d);
  endtask
  task query(input logic [6:0] op, input logic [7:0] arg, input logic [15:0] exp);
    cmd(op, 1'b0, arg);
    rd_reg(`VWSH_ADDR_REPLY, d);
    chk("reply", {16'h0000, exp}, d);
  endtask
  task st(input logic [31:0] mask, input logic [31:0] exp);
    rd_reg(`VWSH_ADDR_STATUS, d);
    chk("status", exp, d & mask);
  endtask
  task stop_test;
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // event tally; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    if (evt_valid === 1'b1) begin
      n_evt++;
      last_evt = evt_word;
    end
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    query(`VWSH_OP_READ_PROT, 8'h00, `VWSH_PROTOCOL_WORD);
    st(32'h67, 32'h60);
    query(`VWSH_OP_READ_NINT, 8'h00, `VWSH_NUM_INTR);
    query(`VWSH_OP_READ_LINE, 8'h00, {13'h0, `VWSH_LINE_DEFAULT});
    do_cmd(`VWSH_OP_ASSIGN_LINE, 1'b0, 8'h05);
    query(`VWSH_OP_READ_LINE, 8'h00, 16'h0005);
    chk("int_line", 32'h5, {29'h0, int_line});
    query(`VWSH_OP_END_NORMAL, 8'h00, `VWSH_STAT_BASE | `VWSH_STAT_NOT_NORMAL);
    do_cmd(`VWSH_OP_BYTE_AVAIL, 1'b1, 8'h41);
    chk("msg_valid", 32'h0, {31'h0, msg_valid});
    query(`VWSH_OP_READ_ERR, 8'h00, `VWSH_ERR_UNSUPPORTED);
    do_cmd(`VWSH_OP_CTRL_RESP, 1'b0, 8'h01);
    st(32'h4, 32'h4);
    do_cmd(`VWSH_OP_CLEAR, 1'b0, 8'h00);
    st(32'h4, 32'h0);
    do_cmd(`VWSH_OP_CTRL_RESP, 1'b0, 8'h00);
    st(32'h4, 32'h0);
    do_cmd(`VWSH_OP_ASYNC_MODE, 1'b0, 8'h01);
    // false event off, then on; the true event stays enabled throughout
    for (int i = 0; i < 2; i++) begin
      do_cmd(`VWSH_OP_CTRL_EVENT, i[0], `VWSH_EVT_REQ_FALSE);
      st(32'h60, i ? 32'h60 : 32'h20);
      @(posedge clk) srq <= 1'b1;
      repeat (4) @(posedge clk);
      srq <= 1'b0;
      repeat (4) @(posedge clk);
      chk("event count", 2 * i + 1, n_evt);
      chk("last event", i ? 32'hfc : 32'hfd, {24'h0, last_evt});
    end
    do_cmd(`VWSH_OP_BEGIN_NORMAL, 1'b1, 8'h00);
    st(32'h3, 32'h3);
    @(posedge clk) stb <= 8'h5a;
    query(`VWSH_OP_READ_STB, 8'h00, 16'h005a);
    // fill the fifo past its depth while the parser stalls, then drain
    @(posedge clk) stall <= 1'b1;
    for (int i = 0; i < 17; i++) cmd(`VWSH_OP_BYTE_AVAIL, i == 15, i[7:0]);
    query(`VWSH_OP_READ_ERR, 8'h00, `VWSH_ERR_DIR);
    @(posedge clk) stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk("bytes", 32'd16, parser_i.got_q.size());
    chk("first byte", 32'h000, {23'h0, parser_i.got_q[0]});
    chk("last byte", 32'h10f, {23'h0, parser_i.got_q[15]});
    do_cmd(`VWSH_OP_CLEAR, 1'b0, 8'h00);
    query(`VWSH_OP_READ_ERR, 8'h00, `VWSH_ERR_UNSUPPORTED);
    parser_i.push(9'h15a);
    query(`VWSH_OP_BYTE_REQ, 8'h00, 16'h015a);
    do_cmd(`VWSH_OP_BYTE_REQ, 1'b0, 8'h00);
    query(`VWSH_OP_READ_ERR, 8'h00, `VWSH_ERR_DOR);
    // a stalled byte left behind is dropped by clear in configure
    @(posedge clk) stall <= 1'b1;
    cmd(`VWSH_OP_BYTE_AVAIL, 1'b0, 8'haa);
    do_cmd(`VWSH_OP_END_NORMAL, 1'b0, 8'h00);
    chk("normal_mode", 32'h0, {31'h0, normal_mode});
    do_cmd(`VWSH_OP_CLEAR, 1'b0, 8'h00);
    chk("msg_valid", 32'h0, {31'h0, msg_valid});
    // abort brings back power-up routing, enables and line
    do_cmd(`VWSH_OP_ABORT_NORMAL, 1'b0, 8'h00);
    st(32'h773, 32'h60);
    stop_test();
  end
endmodule
bind vwsh_core vwsh_sva sva_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
  .wr(wr), .msg_valid(msg_valid), .msg_data(msg_data), .msg_end(msg_end),
  .rsp_valid(rsp_valid), .rsp_take(rsp_take), .srq(srq), .evt_valid(evt_valid),
  .evt_word(evt_word), .int_line(int_line), .normal_mode(normal_mode));

//--- dv/vwsh_parser_model.sv
`timescale 1ns/1ps
// ==========================================================
// parser stand-in: sinks message bytes, sources response bytes
module vwsh_parser_model (
  input  wire        clk,
  input  wire        stall,
  input  wire        msg_valid,
  input  wire [7:0]  msg_data,
  input  wire        msg_end,
  output wire        msg_ready,
  output wire        rsp_valid,
  output wire [7:0]  rsp_data,
  output wire        rsp_end,
  input  wire        rsp_take
);
  logic [8:0] got_q[$];
  logic [8:0] rsp_mem[0:7];
  logic [8:0] last_q = 9'h000;
  int         rd_p   = 0;
  int         wr_p   = 0;
  // stall holds ready low so the fifo can be driven to refusal
  assign msg_ready = !stall;
  // an idle response line shows the inverse of the last byte, never a stale copy
  assign rsp_valid = rd_p != wr_p;
  assign {rsp_end, rsp_data} = rsp_valid ? rsp_mem[rd_p[2:0]] : ~last_q;
  task push(input logic [8:0] v);
    rsp_mem[wr_p[2:0]] = v;
    wr_p++;
  endtask
  // end flag is kept beside each byte; take advances the response
  always @(posedge clk) begin
    if (msg_valid && msg_ready) got_q.push_back({msg_end, msg_data});
    if (rsp_take && rsp_valid) begin
      last_q <= rsp_mem[rd_p[2:0]];
      rd_p   <= rd_p + 1;
    end
  end
endmodule

//--- dv/vwsh_sva.sv
`timescale 1ns/1ps
`include "vwsh_defines.vh"
// ==========================================================
// watcher on the command port, the message head and the events
module vwsh_sva (
  input wire        clk,
  input wire        reset,
  input wire [3:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        msg_valid,
  input wire [7:0]  msg_data,
  input wire        msg_end,
  input wire        rsp_valid,
  input wire        rsp_take,
  input wire        srq,
  input wire        evt_valid,
  input wire [7:0]  evt_word,
  input wire [2:0]  int_line,
  input wire        normal_mode
);
  // decoded command strobe, shared by all but the reset and event properties
  wire       cmd_w  = wr && addr == `VWSH_ADDR_CMD;
  wire [6:0] op     = wdata[`VWSH_OP_RANGE];
  wire       req_ok = cmd_w && op == `VWSH_OP_BYTE_REQ && normal_mode && rsp_valid;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // one command write with a given opcode
  sequence s_cmd(o);
    cmd_w && op == o;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) reset |=> !normal_mode &&
    int_line == 3'h0 && !evt_valid && !msg_valid) else $error("bad reset state");
  a_begin_normal: assert property (s_cmd(`VWSH_OP_BEGIN_NORMAL) ##0 !normal_mode
    |=> normal_mode) else $error("begin did not enter normal");
  a_end_normal: assert property (s_cmd(`VWSH_OP_END_NORMAL) ##0 normal_mode
    |=> !normal_mode) else $error("end did not leave normal");
  a_cfg_no_byte: assert property (s_cmd(`VWSH_OP_BYTE_AVAIL) ##0 !normal_mode
    ##0 !msg_valid |=> !msg_valid) else $error("byte taken in configure");
  a_msg_byte: assert property (s_cmd(`VWSH_OP_BYTE_AVAIL) ##0 normal_mode
    ##0 !msg_valid |=> msg_valid && msg_data == $past(wdata[7:0]) &&
    msg_end == $past(wdata[`VWSH_FLAG_BIT])) else $error("message head wrong");
  a_take_cause: assert property (rsp_take |-> $past(req_ok))
    else $error("response taken without request");
  a_clear_flush: assert property (s_cmd(`VWSH_OP_CLEAR) ##0 !normal_mode
    |=> !msg_valid) else $error("clear left bytes");
  a_evt_true: assert property (evt_valid && evt_word == `VWSH_EVT_REQ_TRUE
    |-> $past(srq) && !$past(srq, 2)) else $error("true event without rise");
  a_evt_false: assert property (evt_valid && evt_word == `VWSH_EVT_REQ_FALSE
    |-> !$past(srq) && $past(srq, 2)) else $error("false event without fall");
  a_line_cause: assert property ($changed(int_line) |-> $past(reset) ||
    $past(cmd_w && !normal_mode && (op == `VWSH_OP_ASSIGN_LINE ||
    op == `VWSH_OP_ABORT_NORMAL))) else $error("line changed on its own");
endmodule
